// ### src/tio_port_unit.sv
// Function
// - All pins of a port share one direction
// - Ports of widths 1, 4, 8, 16, 32
// - Drive pins or sample, optionally on condition
// - Each port instruction completes in one cycle
// - Data passes serdes plus transfer register
// - 16-bit counter times each pin transfer
// - Counter readable; transfers delayable to set time
// - Counter captured as timestamp on each transfer
// - Enabled link disconnects its shared port pins
// - Narrower enabled port wins shared pins
// - Unshared pins stay with the wider port
// - Port always transfers at its own width
// - Six clock blocks; block zero is reference
// - Clock block may take one-bit port clock
// - Strobe in accepted, strobe out with data
// - Reset attaches every port to block zero
// - Pin events go straight to the tile
// - Pins float in reset, pulls enable later
`timescale 1ns/10ps
`default_nettype none
`include "tio_regs.svh"

module tio_port #(parameter int W = 1) (
	input wire logic i_core_clk,
	input wire logic i_rst_b,
	input var tio_pkg::tio_cmd_t i_cmd,
	input wire logic [5:0] i_ticks,
	input wire logic [31:0] i_pins,
	input wire logic i_strobe_in,
	output tio_pkg::tio_cfg_t o_cfg,
	output logic [31:0] o_drive,
	output logic o_strobe_out,
	output logic o_event,
	output tio_pkg::tio_rsp_t o_rsp
);
	localparam int N = 32 / W;
	localparam logic [31:0] MASK = 32'((33'h1 << W) - 33'h1);
	localparam tio_pkg::tio_st_t ST_IDLE = tio_pkg::ST_IDLE;
	localparam tio_pkg::tio_st_t ST_RUN = tio_pkg::ST_RUN;
	tio_pkg::tio_cfg_t cfg_q, cfg_d;
	tio_pkg::tio_st_t st_q, st_d;
	tio_pkg::tio_rsp_t rsp_q, rsp_d;
	logic [15:0] cnt_q, cnt_d, ts_q, ts_d, time_q, time_d;
	logic timed_q, timed_d, full_q, full_d, stb_q, stb_d, ev_q, ev_d;
	logic [31:0] xfer_q, xfer_d, sh_q, sh_d, drv_q, drv_d, cond_q, cond_d;
	logic [5:0] n_q, n_d;
	logic tick, go, cond_ok, sample, done;

	function automatic logic [31:0] shift_in(input logic [31:0] s, input logic [31:0] p);
		shift_in = (s >> W) | (p << (32 - W));
	endfunction : shift_in

	always_comb begin
		cfg_d = cfg_q;
		st_d = st_q;
		rsp_d = '0;
		cnt_d = cnt_q;
		ts_d = ts_q;
		time_d = time_q;
		timed_d = timed_q;
		full_d = full_q;
		xfer_d = xfer_q;
		sh_d = sh_q;
		drv_d = drv_q;
		cond_d = cond_q;
		n_d = n_q;
		stb_d = 1'b0;
		ev_d = 1'b0;
		done = 1'b0;
		tick = (cfg_q.clk < 3'h6) ? i_ticks[cfg_q.clk] : 1'b0;
		if (tick) begin
			cnt_d = cnt_q + 16'h0001;
		end
		go = tick && cfg_q.en && (!timed_q || cnt_q == time_q);
		cond_ok = !cfg_q.cond || ((i_pins ^ cond_q) & MASK) == 32'h0000_0000;
		sample = 1'b0;
		if (cfg_q.out) begin
			if (st_q == ST_IDLE && full_q && go) begin
				sh_d = xfer_q;
				full_d = 1'b0;
				timed_d = 1'b0;
				ts_d = cnt_q;
				n_d = '0;
				st_d = ST_RUN;
			end else if (st_q == ST_RUN && tick) begin
				drv_d = sh_q & MASK;
				sh_d = sh_q >> W;
				stb_d = cfg_q.stb;
				n_d = n_q + 6'h01;
				if (n_q == 6'(N - 1)) begin
					st_d = ST_IDLE;
				end
			end
		end else begin
			// Strobe-qualified sampling lets slow external logic pace the input
			if (st_q == ST_IDLE && go && cond_ok && (!cfg_q.stb || i_strobe_in)) begin
				sample = 1'b1;
				timed_d = 1'b0;
				ts_d = cnt_q;
				n_d = '0;
			end else if (st_q == ST_RUN && tick && (!cfg_q.stb || i_strobe_in)) begin
				sample = 1'b1;
			end
			if (sample) begin
				sh_d = shift_in(sh_q, i_pins);
				n_d = (st_q == ST_IDLE) ? 6'h01 : n_q + 6'h01;
				st_d = ST_RUN;
				if ((st_q == ST_IDLE ? 6'h00 : n_q) == 6'(N - 1)) begin
					xfer_d = shift_in(sh_q, i_pins);
					full_d = 1'b1;
					done = 1'b1;
					ev_d = 1'b1;
					st_d = ST_IDLE;
				end
			end
		end
		if (i_cmd.valid) begin
			rsp_d.valid = 1'b1;
			rsp_d.ok = 1'b1;
			rsp_d.stamp = ts_q;
			unique case (i_cmd.op)
				tio_pkg::OP_CFG: begin
					cfg_d.en = i_cmd.data[`TIO_CFG_EN];
					cfg_d.out = i_cmd.data[`TIO_CFG_OUT];
					cfg_d.clk = i_cmd.data[`TIO_CFG_CLK +: 3];
					cfg_d.cond = i_cmd.data[`TIO_CFG_COND];
					cfg_d.stb = i_cmd.data[`TIO_CFG_STB];
					st_d = ST_IDLE;
					full_d = 1'b0;
				end
				tio_pkg::OP_OUT: begin
					rsp_d.ok = !full_d;
					if (!full_d) begin
						xfer_d = i_cmd.data;
						full_d = 1'b1;
					end
				end
				tio_pkg::OP_IN: begin
					rsp_d.ok = full_q;
					rsp_d.data = xfer_q;
					// A word landing in this same cycle is kept, not cleared
					if (!done) begin
						full_d = 1'b0;
					end
				end
				tio_pkg::OP_TIME: begin
					time_d = i_cmd.data[15:0];
					timed_d = i_cmd.data[`TIO_TIME_ARM];
				end
				tio_pkg::OP_COND: cond_d = i_cmd.data;
				tio_pkg::OP_CNT: rsp_d.data = {16'h0000, cnt_q};
				default: rsp_d.ok = 1'b0;
			endcase
		end
	end

	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			cfg_q <= '{en: 1'b0, out: 1'b0, clk: `TIO_CLK_RST, cond: 1'b0, stb: 1'b0};
			st_q <= ST_IDLE;
			rsp_q <= '0;
			cnt_q <= 16'h0000;
			ts_q <= 16'h0000;
			time_q <= 16'h0000;
			timed_q <= 1'b0;
			full_q <= 1'b0;
			xfer_q <= 32'h0000_0000;
			sh_q <= 32'h0000_0000;
			drv_q <= 32'h0000_0000;
			cond_q <= 32'h0000_0000;
			n_q <= 6'h00;
			stb_q <= 1'b0;
			ev_q <= 1'b0;
		end else begin
			cfg_q <= cfg_d;
			st_q <= st_d;
			rsp_q <= rsp_d;
			cnt_q <= cnt_d;
			ts_q <= ts_d;
			time_q <= time_d;
			timed_q <= timed_d;
			full_q <= full_d;
			xfer_q <= xfer_d;
			sh_q <= sh_d;
			drv_q <= drv_d;
			cond_q <= cond_d;
			n_q <= n_d;
			stb_q <= stb_d;
			ev_q <= ev_d;
		end
	end

	assign o_cfg = cfg_q;
	assign o_drive = drv_q;
	assign o_strobe_out = stb_q;
	assign o_event = ev_q;
	assign o_rsp = rsp_q;

	a_cmd_one_cycle: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
		i_cmd.valid |=> o_rsp.valid) else $error("port command not answered next cycle");
	a_cnt_step: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
		tick |=> cnt_q == $past(cnt_q) + 16'h0001) else $error("counter missed a tick");
	a_timed_start: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
		(st_q == ST_IDLE && st_d == ST_RUN && timed_q && !i_cmd.valid) |-> cnt_q == time_q)
		else $error("timed transfer began off its time");
	a_stamp_take: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
		(st_q == ST_IDLE && st_d == ST_RUN && !i_cmd.valid) |=> ts_q == $past(cnt_q))
		else $error("timestamp not captured");
	a_strobe_data: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
		o_strobe_out |-> $past(cfg_q.stb && st_q == ST_RUN && tick))
		else $error("strobe without output data");
	a_word_count: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
		done |-> (st_q == ST_IDLE ? 6'h00 : n_q) == 6'(N - 1)) else $error("word width wrong");
	c_timed_out: cover property (@(posedge i_core_clk) disable iff (!i_rst_b)
		cfg_q.out && timed_q && st_d == ST_RUN);
	c_in_word: cover property (@(posedge i_core_clk) disable iff (!i_rst_b) done && cfg_q.cond);
endmodule : tio_port

module tio_port_unit #(parameter int PULL_CYCLES = `TIO_PULL_CLKS) (
	input wire logic i_core_clk,
	input wire logic i_rst_b,
	input var tio_pkg::tio_cmd_t i_cmd,
	input wire logic i_link_en,
	input wire logic [31:0] i_pins,
	input wire logic [4:0] i_strobe_in,
	output tio_pkg::tio_rsp_t o_rsp,
	output logic [31:0] o_pins,
	output logic [31:0] o_pins_oe,
	output logic [4:0] o_strobe_out,
	output logic [4:0] o_event,
	output logic o_pull_en
);
	localparam int PW [5] = '{`TIO_W0, `TIO_W1, `TIO_W2, `TIO_W3, `TIO_W4};
	logic [31:0] pin_s1_q, pin_s2_q, pins_q, pins_d, oe_q, oe_d;
	logic [4:0] stb_s1_q, stb_s2_q;
	// Strobe is retimed to leave with the pin register, not a cycle ahead of it
	logic [4:0] stb_raw, stb_out_q;
	logic clk_pin_q, pull_q, pull_d;
	logic [19:0] pull_cnt_q, pull_cnt_d;
	logic [7:0] div_q [6], div_d [6], cb_cnt_q [6], cb_cnt_d [6];
	logic [5:0] src_q, src_d, ticks;
	logic [31:0] drv [5];
	tio_pkg::tio_cfg_t cfg [5];
	tio_pkg::tio_rsp_t rsp [5];

	for (genvar k = 0; k < `TIO_NPORTS; k++) begin : g_port
		tio_pkg::tio_cmd_t pcmd;
		assign pcmd = '{valid: i_cmd.valid && i_cmd.sel == 3'(k) && i_cmd.op != tio_pkg::OP_CLKB,
			op: i_cmd.op, sel: i_cmd.sel, data: i_cmd.data};
		tio_port #(.W(PW[k])) u_port (
			.i_core_clk(i_core_clk),
			.i_rst_b(i_rst_b),
			.i_cmd(pcmd),
			.i_ticks(ticks),
			.i_pins(pin_s2_q),
			.i_strobe_in(stb_s2_q[k]),
			.o_cfg(cfg[k]),
			.o_drive(drv[k]),
			.o_strobe_out(stb_raw[k]),
			.o_event(o_event[k]),
			.o_rsp(rsp[k])
		);
	end

	always_comb begin
		logic found;
		found = 1'b0;
		pins_d = '0;
		oe_d = '0;
		for (int i = 0; i < `TIO_NPINS; i++) begin
			found = 1'b0;
			for (int k = 0; k < `TIO_NPORTS; k++) begin
				if (!found && cfg[k].en && i < PW[k]) begin
					found = 1'b1;
					oe_d[i] = cfg[k].out;
					pins_d[i] = drv[k][i];
				end
			end
			if (i_link_en && i >= `TIO_LINK_LO) begin
				oe_d[i] = 1'b0;
			end
		end
		pull_cnt_d = pull_cnt_q;
		pull_d = pull_q;
		if (pull_cnt_q < 20'(PULL_CYCLES)) begin
			pull_cnt_d = pull_cnt_q + 20'h00001;
		end else begin
			pull_d = 1'b1;
		end
		src_d = src_q;
		for (int b = 0; b < `TIO_NCLKB; b++) begin
			div_d[b] = div_q[b];
			// Block zero stays on the reference so a reset port always runs
			ticks[b] = (b == 0) ? 1'b1 : (src_q[b] ? (pin_s2_q[0] && !clk_pin_q)
				: cb_cnt_q[b] == div_q[b]);
			cb_cnt_d[b] = ticks[b] ? 8'h00 : cb_cnt_q[b] + 8'h01;
			if (i_cmd.valid && i_cmd.op == tio_pkg::OP_CLKB && i_cmd.sel == 3'(b) && b != 0) begin
				div_d[b] = i_cmd.data[7:0];
				src_d[b] = i_cmd.data[`TIO_CB_SRC];
			end
		end
		o_rsp = '0;
		for (int k = 0; k < `TIO_NPORTS; k++) begin
			o_rsp = o_rsp | rsp[k];
		end
	end

	always_ff @(posedge i_core_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			pin_s1_q <= '0;
			pin_s2_q <= '0;
			stb_s1_q <= '0;
			stb_s2_q <= '0;
			stb_out_q <= '0;
			clk_pin_q <= 1'b0;
			pins_q <= '0;
			oe_q <= '0;
			pull_q <= 1'b0;
			pull_cnt_q <= 20'h00000;
			src_q <= 6'h00;
			for (int b = 0; b < `TIO_NCLKB; b++) begin
				div_q[b] <= 8'h00;
				cb_cnt_q[b] <= 8'h00;
			end
		end else begin
			pin_s1_q <= i_pins;
			pin_s2_q <= pin_s1_q;
			stb_s1_q <= i_strobe_in;
			stb_s2_q <= stb_s1_q;
			stb_out_q <= stb_raw;
			clk_pin_q <= pin_s2_q[0];
			pins_q <= pins_d;
			oe_q <= oe_d;
			pull_q <= pull_d;
			pull_cnt_q <= pull_cnt_d;
			src_q <= src_d;
			div_q <= div_d;
			cb_cnt_q <= cb_cnt_d;
		end
	end

	assign o_pins = pins_q;
	assign o_strobe_out = stb_out_q;
	assign o_pins_oe = oe_q;
	assign o_pull_en = pull_q;

	a_link_off: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
		$past(i_link_en) |-> o_pins_oe[31:24] == 8'h00) else $error("link pins still driven");
	a_narrow_wins: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
		(cfg[0].en && !cfg[0].out && !i_link_en) |=> !o_pins_oe[0]) else $error("wide port took pin");
	a_pull_late: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
		o_pull_en |-> pull_cnt_q == 20'(PULL_CYCLES)) else $error("pulls enabled early");
	c_link_on: cover property (@(posedge i_core_clk) disable iff (!i_rst_b) i_link_en && oe_d != '0);
	c_pin_clock: cover property (@(posedge i_core_clk) disable iff (!i_rst_b) src_q[1] && ticks[1]);
endmodule : tio_port_unit

`default_nettype wire

// ### src/tio_regs.svh
`ifndef TIO_REGS_SVH
`define TIO_REGS_SVH
`define TIO_NPINS 32
`define TIO_NPORTS 5
`define TIO_NCLKB 6
`define TIO_W0 1
`define TIO_W1 4
`define TIO_W2 8
`define TIO_W3 16
`define TIO_W4 32
`define TIO_LINK_LO 24
`define TIO_PULL_CLKS 750000
`define TIO_CFG_EN 0
`define TIO_CFG_OUT 1
`define TIO_CFG_CLK 2
`define TIO_CFG_COND 5
`define TIO_CFG_STB 6
`define TIO_CB_SRC 8
`define TIO_TIME_ARM 16
`define TIO_CLK_RST 3'h0
`endif

// ### src/tio_pkg.sv
package tio_pkg;
	typedef enum logic [2:0] {
		OP_NOP, OP_CFG, OP_OUT, OP_IN, OP_TIME, OP_COND, OP_CNT, OP_CLKB
	} tio_op_t;
	typedef struct packed {
		logic valid;
		tio_op_t op;
		logic [2:0] sel;
		logic [31:0] data;
	} tio_cmd_t;
	typedef struct packed {
		logic valid;
		logic ok;
		logic [31:0] data;
		logic [15:0] stamp;
	} tio_rsp_t;
	typedef struct packed {
		logic en;
		logic out;
		logic [2:0] clk;
		logic cond;
		logic stb;
	} tio_cfg_t;
	typedef enum logic {ST_IDLE, ST_RUN} tio_st_t;
endpackage : tio_pkg

// ### verification/tio_ext_hw.sv
`timescale 1ns/10ps
`default_nettype none

module tio_ext_hw (
	input wire logic i_core_clk,
	input wire logic [31:0] i_dev_pins,
	input wire logic [31:0] i_dev_oe,
	input wire logic i_pull_en,
	input wire logic [31:0] i_ext_en,
	input wire logic [31:0] i_ext_val,
	output logic [31:0] o_level,
	output logic [4:0] o_strobe
);
	logic [31:0] last_q = 32'h0000_0000;
	always_ff @(posedge i_core_clk) begin
		last_q <= o_level;
	end
	// Undriven pins without pulls toggle so a settled unknown never looks valid
	always_comb begin
		for (int i = 0; i < 32; i++) begin
			if (i_dev_oe[i]) begin
				o_level[i] = i_dev_pins[i];
			end else if (i_ext_en[i]) begin
				o_level[i] = i_ext_val[i];
			end else if (i_pull_en) begin
				o_level[i] = 1'b0;
			end else begin
				o_level[i] = ~last_q[i];
			end
		end
	end
	assign o_strobe = 5'h1F;
endmodule : tio_ext_hw
`default_nettype wire

// ### verification/tb_timed_io_port_clock_blocks.sv
`timescale 1ns/10ps
`default_nettype none

module tb_timed_io_port_clock_blocks;
	logic i_core_clk, i_rst_b, i_link_en, o_pull_en;
	tio_pkg::tio_cmd_t i_cmd;
	tio_pkg::tio_rsp_t o_rsp, rsp;
	logic [31:0] pins_lvl, o_pins, o_pins_oe, ext_en, ext_val;
	logic [31:0] d1;
	logic [4:0] strobe_lvl, o_strobe_out, o_event;
	logic [15:0] c0;
	int fail_count = 0;
	int total_checks = 0;
	int n;
	tio_port_unit #(.PULL_CYCLES(20)) i_tio_port_unit (.i_core_clk(i_core_clk),
		.i_rst_b(i_rst_b), .i_cmd(i_cmd), .i_link_en(i_link_en), .i_pins(pins_lvl),
		.i_strobe_in(strobe_lvl), .o_rsp(o_rsp), .o_pins(o_pins), .o_pins_oe(o_pins_oe),
		.o_strobe_out(o_strobe_out), .o_event(o_event), .o_pull_en(o_pull_en));
	tio_ext_hw i_tio_ext_hw (.i_core_clk(i_core_clk), .i_dev_pins(o_pins),
		.i_dev_oe(o_pins_oe), .i_pull_en(o_pull_en), .i_ext_en(ext_en),
		.i_ext_val(ext_val), .o_level(pins_lvl), .o_strobe(strobe_lvl));
	initial begin
		i_core_clk = 1'b0;
		forever #25 i_core_clk = ~i_core_clk;
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	// Called at a falling edge; the answer stands only in the cycle after the taking edge
	task automatic cmd(input tio_pkg::tio_op_t op, input logic [2:0] sel, input logic [31:0] d);
		i_cmd = '{1'b1, op, sel, d};
		@(negedge i_core_clk);
		rsp = o_rsp;
		i_cmd = '0;
		@(negedge i_core_clk);
		if (op != tio_pkg::OP_CLKB) check(rsp.valid, 1'b1);
	endtask : cmd
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : report_and_stop
	task automatic t_reset();
		check(o_pins_oe, 32'h0);
		check(o_pull_en, 1'b0);
		i_rst_b = 1'b1;
		repeat (20) @(negedge i_core_clk);
		check(o_pull_en, 1'b0);
		@(negedge i_core_clk);
		check(o_pull_en, 1'b1);
		$display("test reset done");
	endtask : t_reset
	task automatic t_counter();
		cmd(tio_pkg::OP_CFG, 3'h0, 32'h1);
		cmd(tio_pkg::OP_CNT, 3'h0, 32'h0);
		c0 = rsp.data[15:0];
		repeat (5) @(negedge i_core_clk);
		cmd(tio_pkg::OP_CNT, 3'h0, 32'h0);
		check(16'(rsp.data[15:0] - c0), 32'h7);
		cmd(tio_pkg::OP_CLKB, 3'h1, 32'h3);
		cmd(tio_pkg::OP_CFG, 3'h2, 32'h5);
		cmd(tio_pkg::OP_CNT, 3'h2, 32'h0);
		c0 = rsp.data[15:0];
		repeat (6) @(negedge i_core_clk);
		cmd(tio_pkg::OP_CNT, 3'h2, 32'h0);
		check(16'(rsp.data[15:0] - c0), 32'h2);
		$display("test counter done");
	endtask : t_counter
	task automatic t_output();
		d1 = 32'h8765_4321;
		cmd(tio_pkg::OP_CFG, 3'h0, 32'h0);
		cmd(tio_pkg::OP_CFG, 3'h1, 32'h43);
		cmd(tio_pkg::OP_OUT, 3'h1, d1);
		check(rsp.ok, 1'b1);
		cmd(tio_pkg::OP_OUT, 3'h1, 32'hA5A5_5A5A);
		check(rsp.ok, 1'b1);
		n = 0;
		for (int k = 0; k < 8; k++) begin
			check(o_pins[3:0], d1[4 * k +: 4]);
			check(o_pins_oe[3:0], 4'hF);
			if (o_strobe_out[1] === 1'b1) n++;
			@(negedge i_core_clk);
		end
		check(n, 8);
		cmd(tio_pkg::OP_OUT, 3'h1, 32'h1);
		check(rsp.ok, 1'b1);
		cmd(tio_pkg::OP_OUT, 3'h1, 32'h2);
		check(rsp.ok, 1'b0);
		$display("test output done");
	endtask : t_output
	task automatic t_input();
		ext_en = 32'h1;
		cmd(tio_pkg::OP_CFG, 3'h1, 32'h0);
		repeat (3) @(negedge i_core_clk);
		cmd(tio_pkg::OP_CFG, 3'h0, 32'h1);
		cmd(tio_pkg::OP_IN, 3'h0, 32'h0);
		check(rsp.ok, 1'b0);
		n = 0;
		while (o_event[0] !== 1'b1 && n < 80) begin
			@(negedge i_core_clk);
			n++;
		end
		check(o_event[0], 1'b1);
		cmd(tio_pkg::OP_IN, 3'h0, 32'h0);
		check(rsp.ok, 1'b1);
		check(rsp.data, 32'hFFFF_FFFF);
		cmd(tio_pkg::OP_COND, 3'h0, 32'h0);
		cmd(tio_pkg::OP_CFG, 3'h0, 32'h21);
		repeat (40) @(negedge i_core_clk);
		cmd(tio_pkg::OP_IN, 3'h0, 32'h0);
		check(rsp.ok, 1'b0);
		ext_val = 32'h0;
		repeat (40) @(negedge i_core_clk);
		cmd(tio_pkg::OP_IN, 3'h0, 32'h0);
		check(rsp.ok, 1'b1);
		check(rsp.data, 32'h0);
		$display("test input done");
	endtask : t_input
	task automatic t_timed();
		cmd(tio_pkg::OP_CFG, 3'h1, 32'h3);
		cmd(tio_pkg::OP_CNT, 3'h1, 32'h0);
		c0 = rsp.data[15:0] + 16'h0020;
		cmd(tio_pkg::OP_TIME, 3'h1, {16'h0001, c0});
		cmd(tio_pkg::OP_OUT, 3'h1, d1);
		repeat (10) @(negedge i_core_clk);
		cmd(tio_pkg::OP_OUT, 3'h1, d1);
		check(rsp.ok, 1'b0);
		repeat (30) @(negedge i_core_clk);
		cmd(tio_pkg::OP_CNT, 3'h1, 32'h0);
		check(rsp.stamp, c0);
		$display("test timed done");
	endtask : t_timed
	task automatic t_sharing();
		cmd(tio_pkg::OP_CFG, 3'h4, 32'h3);
		repeat (4) @(negedge i_core_clk);
		check(o_pins_oe, 32'hFFFF_FF0E);
		i_link_en = 1'b1;
		repeat (4) @(negedge i_core_clk);
		check(o_pins_oe, 32'h00FF_FF0E);
		i_link_en = 1'b0;
		$display("test sharing done");
	endtask : t_sharing
	initial begin
		i_rst_b = 1'b0;
		i_cmd = '0;
		i_link_en = 1'b0;
		ext_en = 32'h0;
		ext_val = 32'hFFFF_FFFF;
		repeat (16) @(negedge i_core_clk);
		t_reset();
		t_counter();
		t_output();
		t_input();
		t_timed();
		t_sharing();
		report_and_stop();
	end
	// Whole run needs a few hundred cycles; this leaves a wide margin
	initial begin
		repeat (3000) @(posedge i_core_clk);
		fail_count++;
		report_and_stop();
	end
endmodule : tb_timed_io_port_clock_blocks
`default_nettype wire
